//--- bit_unit_pkg.sv
// Purpose: shared constants for the bit and/compare execution unit
// Assumes: 8-bit register file, 8-bit flags register
// Notes:   flag bit positions follow the flags register layout
package bit_unit_pkg;
  localparam logic [7:0] opc_bit_and     = 8'h67;
  localparam logic [7:0] opc_bit_compare = 8'h17;
  localparam logic [7:0] flags_addr      = 8'hd5;
  localparam logic [7:0] work_reg_base   = 8'hc0;
  localparam int         instr_bytes     = 3;
  localparam int         instr_cycles    = 6;
  localparam int         flag_c_pos      = 7;
  localparam int         flag_z_pos      = 6;
  localparam int         flag_s_pos      = 5;
  localparam int         flag_v_pos      = 4;
  localparam int         flag_d_pos      = 3;
  localparam int         flag_h_pos      = 2;
  localparam int         sel_pos         = 0;
  localparam int         bidx_lsb        = 1;
  localparam int         addr_lsb        = 4;
  localparam logic [2:0] cyc_last        = 3'h5;
endpackage

//--- bit_op_core.sv
// Purpose: combinational bit and / bit compare result and flag update
// Assumes: operands already fetched
// Notes:   overflow is left at its previous value (undefined per op)
`timescale 1ns/10ps
module bit_op_core (
  input  wire logic       is_compare,
  input  wire logic       to_bit,
  input  wire logic [2:0] bit_idx,
  input  wire logic [7:0] work_val,
  input  wire logic [7:0] reg_val,
  input  wire logic [7:0] flags_in,
  output logic      [7:0] result,
  output logic      [7:0] flags_out
);
  logic sel_bit;
  logic lsb_bit;
  logic res_bit;
  always_comb begin
    // form 0: work.0 with reg.b; form 1: reg.b with work.0
    sel_bit = reg_val[bit_idx];
    lsb_bit = work_val[0];
    res_bit = sel_bit & lsb_bit;
    result = to_bit ? reg_val : work_val;
    if (to_bit) begin
      result[bit_idx] = res_bit;
    end else begin
      result[0] = res_bit;
    end
    flags_out = flags_in;
    if (is_compare) begin
      flags_out[bit_unit_pkg::flag_z_pos] = ~(lsb_bit ^ sel_bit);
    end else begin
      flags_out[bit_unit_pkg::flag_z_pos] = ~res_bit;
    end
    flags_out[bit_unit_pkg::flag_s_pos] = 1'b0;
  end
endmodule

//--- bit_and_compare_unit.sv
// What this block does
// - bit and ands one operand's chosen bit with the other's bit 0.
// - the result bit lands in the chosen destination bit, others kept.
// - bit and never writes the source register.
// - bit and sets zero on a 0 result, clears sign, keeps c d h.
// - bit and is the 3-byte opcode 67h, 6 cycles, in both forms.
// - byte two: 4-bit work address, 3-bit bit index, form bit lsb.
// - bit compare subtracts the source bit from dest bit 0, no store.
// - bit compare sets zero on equal bits, clears sign, keeps others.
// - bit compare leaves both operand registers untouched.
// - bit compare is 3-byte opcode 17h, 6 cycles, same byte two.
// - the zero flag lives in the flags register at address 0d5h.
//
// Purpose: executes the bit and / bit compare instructions
// Assumes: register file reads return data in the next cycle
// Notes:   start pulses with all three instruction bytes present
`timescale 1ns/10ps
module bit_and_compare_unit (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] byte2,
  input  wire logic [7:0] byte3,
  input  wire logic [7:0] rf_rdata,
  output logic            busy,
  output logic            done,
  output logic            illegal,
  output logic      [7:0] rf_addr,
  output logic            rf_rd,
  output logic            rf_wr,
  output logic      [7:0] rf_wdata
);
  typedef enum logic [2:0] {
    st_idle, st_rd_work, st_rd_reg, st_rd_flags, st_exec, st_wr_flags
  } state_e;

  state_e     state_reg;
  logic [2:0] cyc_reg;
  logic       cmp_reg;
  logic       form_reg;
  logic [2:0] bidx_reg;
  logic [3:0] work_reg;
  logic [7:0] regaddr_reg;
  logic [7:0] work_val_reg;
  logic [7:0] reg_val_reg;
  logic [7:0] flags_val_reg;
  logic [7:0] result;
  logic [7:0] flags_new;
  logic       is_and;
  logic       is_cmp;
  logic [7:0] work_addr;
  logic       accept;
  logic       last_cyc;

  assign is_and = opcode == bit_unit_pkg::opc_bit_and;
  assign is_cmp = opcode == bit_unit_pkg::opc_bit_compare;
  assign work_addr = bit_unit_pkg::work_reg_base | {4'h0, work_reg};
  assign accept = state_reg == st_idle && start
                  && (is_and || is_cmp);
  assign last_cyc = state_reg == st_wr_flags
                    && cyc_reg == bit_unit_pkg::cyc_last;

  bit_op_core core (
    .is_compare (cmp_reg),
    .to_bit     (form_reg),
    .bit_idx    (bidx_reg),
    .work_val   (work_val_reg),
    .reg_val    (reg_val_reg),
    .flags_in   (flags_val_reg),
    .result     (result),
    .flags_out  (flags_new)
  );

  // decode latch
  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_reg     <= 1'b0;
      form_reg    <= 1'b0;
      bidx_reg    <= 3'h0;
      work_reg    <= 4'h0;
      regaddr_reg <= 8'h00;
    end else if (state_reg == st_idle && start && (is_and || is_cmp)) begin
      cmp_reg     <= is_cmp;
      // compare always uses the bit-0-of-dest form
      form_reg    <= is_and
                     & byte2[bit_unit_pkg::sel_pos];
      bidx_reg    <=
        byte2[bit_unit_pkg::bidx_lsb +: 3];
      work_reg    <= byte2[bit_unit_pkg::addr_lsb +: 4];
      regaddr_reg <= byte3;
    end
  end

  // sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: begin
          if (start && (is_and || is_cmp)) begin
            state_reg <= st_rd_work;
          end
        end
        st_rd_work:  state_reg <= st_rd_reg;
        st_rd_reg:   state_reg <= st_rd_flags;
        st_rd_flags: state_reg <= st_exec;
        st_exec:     state_reg <= st_wr_flags;
        st_wr_flags: begin
          if (cyc_reg == bit_unit_pkg::cyc_last) begin
            state_reg <= st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // cycle count, six cycles from start to done
  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_reg <= 3'h0;
    end else if (state_reg == st_idle) begin
      // accept loads 1 so that cyc_last marks the sixth cycle
      cyc_reg <= accept ? 3'h1 : 3'h0;
    end else if (cyc_reg != bit_unit_pkg::cyc_last) begin
      cyc_reg <= cyc_reg + 3'h1;
    end
  end

  // operand capture, data arrives a cycle after each read
  always_ff @(posedge clock) begin
    if (rst) begin
      work_val_reg  <= 8'h00;
      reg_val_reg   <= 8'h00;
      flags_val_reg <= 8'h00;
    end else begin
      if (state_reg == st_rd_reg) begin
        work_val_reg <= rf_rdata;
      end
      if (state_reg == st_rd_flags) begin
        reg_val_reg <= rf_rdata;
      end
      if (state_reg == st_exec) begin
        flags_val_reg <= rf_rdata;
      end
    end
  end

  // register file port
  always_ff @(posedge clock) begin
    if (rst) begin
      rf_addr  <= 8'h00;
      rf_rd    <= 1'b0;
      rf_wr    <= 1'b0;
      rf_wdata <= 8'h00;
    end else begin
      rf_rd <= 1'b0;
      rf_wr <= 1'b0;
      case (state_reg)
        st_idle: begin
          if (start && (is_and || is_cmp)) begin
            rf_addr <= bit_unit_pkg::work_reg_base
                       | {4'h0, byte2[bit_unit_pkg::addr_lsb +: 4]};
            rf_rd   <= 1'b1;
          end
        end
        st_rd_work: begin
          rf_addr <= regaddr_reg;
          rf_rd   <= 1'b1;
        end
        st_rd_reg: begin
          rf_addr <= bit_unit_pkg::flags_addr;
          rf_rd   <= 1'b1;
        end
        st_rd_flags: begin
          // operand data lands this cycle, port stays quiet
          rf_rd <= 1'b0;
        end
        st_exec: begin
          // compare stores nothing; and writes only the destination
          if (!cmp_reg) begin
            rf_addr  <= form_reg ? regaddr_reg
                                 : work_addr;
            rf_wdata <= result;
            rf_wr    <= 1'b1;
          end
        end
        st_wr_flags: begin
          if (cyc_reg == bit_unit_pkg::cyc_last) begin
            rf_addr  <= bit_unit_pkg::flags_addr;
            rf_wdata <= flags_new;
            rf_wr    <= 1'b1;
          end
        end
        default: begin
          rf_rd <= 1'b0;
        end
      endcase
    end
  end

  // status
  always_ff @(posedge clock) begin
    if (rst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      illegal <= state_reg == st_idle && start && !(is_and || is_cmp);
      done    <= last_cyc;
      // busy drops with done, so a start in the done cycle is taken
      if (accept) begin
        busy <= 1'b1;
      end else if (last_cyc) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

//--- rf_model.sv
// Purpose: register file model facing the bit unit
// Assumes: read data is returned the cycle after rf_rd
// Notes:   idle read data shows the inverse of its last value
`timescale 1ns/10ps
module rf_model (
  input  wire logic       clock,
  input  wire logic [7:0] rf_addr,
  input  wire logic       rf_rd,
  input  wire logic       rf_wr,
  input  wire logic [7:0] rf_wdata,
  output logic      [7:0] rf_rdata
);
  logic [7:0] mem [256];
  initial rf_rdata = 8'h00;
  always @(posedge clock) begin
    if (rf_wr) mem[rf_addr] <= rf_wdata;
    rf_rdata <= rf_rd ? mem[rf_addr] : ~rf_rdata;
  end
endmodule

//--- bit_and_compare_unit_sva.sv
// Purpose: port timing checks of the bit unit
// Assumes: read data comes one cycle after rf_rd
// Notes:   attached by bind
`timescale 1ns/10ps
module bit_and_compare_unit_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [7:0] rf_rdata,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       illegal,
  input wire logic [7:0] rf_addr,
  input wire logic       rf_rd,
  input wire logic       rf_wr,
  input wire logic [7:0] rf_wdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic idle = start && !busy;
  wire logic a_go = idle && opcode == bit_unit_pkg::opc_bit_and;
  wire logic c_go = idle && opcode == bit_unit_pkg::opc_bit_compare;
  wire logic go = a_go || c_go;
  chk_work_read: assert property (go |=> rf_rd &&
    rf_addr == {4'hc, $past(byte2[7:4])}) else $error("work read");
  chk_src_read: assert property (go |=> ##1 rf_rd &&
    rf_addr == $past(byte3, 2)) else $error("source read");
  chk_flags_read: assert property (go |-> ##3 rf_rd &&
    rf_addr == bit_unit_pkg::flags_addr) else $error("flags read");
  chk_and_writes: assert property (a_go |-> ##5 rf_wr ##1 (rf_wr &&
    rf_addr == bit_unit_pkg::flags_addr && done)) else $error("and writes");
  chk_cmp_nostore: assert property (c_go |=> (!rf_wr)[*5] ##1
    (rf_wr && rf_addr == bit_unit_pkg::flags_addr && done))
    else $error("compare writes");
  chk_sign_clear: assert property (done |-> rf_wr &&
    rf_addr == bit_unit_pkg::flags_addr &&
    !rf_wdata[bit_unit_pkg::flag_s_pos]) else $error("sign not cleared");
  chk_busy_span: assert property (go |=> busy[*5] ##1
    (!busy && done)) else $error("busy span");
  chk_illegal_pulse: assert property (idle && !go |=> illegal &&
    !busy && !rf_rd ##1 !illegal) else $error("illegal pulse");
endmodule

//--- testbench.sv
// Purpose: self-checking bench of the bit unit
// Assumes: register file model answers reads
// Notes:   inputs change at the falling edge
`timescale 1ns/10ps
module testbench;
  logic       clock = 1'b0, rst = 1'b1, start = 1'b0;
  logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00;
  logic [7:0] rf_rdata, rf_addr, rf_wdata;
  logic       busy, done, illegal, rf_rd, rf_wr;
  int         fail_count = 0, n_compared = 0;
  always #10 clock = ~clock;
  bit_and_compare_unit bit_and_compare_unit_inst (.clock(clock), .rst(rst),
    .start(start), .opcode(opcode), .byte2(byte2), .byte3(byte3),
    .rf_rdata(rf_rdata), .busy(busy), .done(done), .illegal(illegal),
    .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata));
  rf_model rf_model_inst (.clock(clock), .rf_addr(rf_addr), .rf_rd(rf_rd),
    .rf_wr(rf_wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] rd(logic [7:0] a);
    return rf_model_inst.mem[a];
  endfunction
  // w work value, s byte-three register value, f flags value
  task automatic run(logic [7:0] op, b2, b3, w, s, f);
    int n;
    rf_model_inst.mem[{4'hc, b2[7:4]}] = w;
    rf_model_inst.mem[b3] = s;
    rf_model_inst.mem[8'hd5] = f;
    @(negedge clock);
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (n == 20) fail_count++;
    // the flags write reaches the register file one edge after done
    if (done === 1'b1) @(negedge clock);
  endtask
  task automatic t_and_lsb();
    run(8'h67, 8'h12, 8'h01, 8'h07, 8'h05, 8'hac);
    check("work", 8'h06, rd(8'hc1));
    check("src", 8'h05, rd(8'h01));
    check("flags", 8'hcc, rd(8'hd5));
    run(8'h67, 8'h12, 8'h01, 8'h07, 8'h07, 8'hff);
    check("work", 8'h07, rd(8'hc1));
    check("flags", 8'h9f, rd(8'hd5));
    $display("test and_lsb done");
  endtask
  task automatic t_and_bit();
    for (int b = 0; b < 8; b++) begin
      run(8'h67, {4'h3, b[2:0], 1'b1}, 8'h21, 8'h06, 8'hff, 8'h00);
      check("dst", ~(8'h01 << b), rd(8'h21));
      check("work", 8'h06, rd(8'hc3));
      check("flags", 8'h40, rd(8'hd5));
    end
    $display("test and_bit done");
  endtask
  task automatic t_compare();
    run(8'h17, 8'h12, 8'h01, 8'h07, 8'h01, 8'h60);
    check("flags", 8'h00, rd(8'hd5));
    check("work", 8'h07, rd(8'hc1));
    run(8'h17, 8'h13, 8'h01, 8'h07, 8'h02, 8'h8c);
    check("flags", 8'hcc, rd(8'hd5));
    check("src", 8'h02, rd(8'h01));
    $display("test compare done");
  endtask
  task automatic t_illegal();
    run(8'h52, 8'h12, 8'h01, 8'h07, 8'h05, 8'h00);
    check("illegal", 8'h01, {7'h00, illegal});
    check("busy", 8'h00, {7'h00, busy});
    check("work", 8'h07, rd(8'hc1));
    $display("test illegal done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    t_and_lsb();
    t_and_bit();
    t_compare();
    t_illegal();
    conclude();
  end
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule
bind bit_and_compare_unit bit_and_compare_unit_sva chk_inst (.clock(clock),
  .rst(rst), .start(start), .opcode(opcode), .byte2(byte2), .byte3(byte3),
  .rf_rdata(rf_rdata), .busy(busy), .done(done), .illegal(illegal),
  .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata));
